// File: core/dsps_pin_sync.v
// three-stage synchroniser, change accepted when stages 2 and 3 agree
module dsps_pin_sync (
    input  wire aclk,
    input  wire aresetn,
    input  wire ce,
    input  wire pin,
    output reg  level
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    // s1 is only read by s2
    always @(posedge aclk) begin
        if (!aresetn) begin
            s1_q  <= 1'b0;
            s2_q  <= 1'b0;
            s3_q  <= 1'b0;
            level <= 1'b0;
        end else if (ce) begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level <= s3_q;
            end
        end
    end
endmodule

// File: core/dsps_regs.vh
`ifndef DSPS_REGS_VH
`define DSPS_REGS_VH

// register byte offsets of the controller's own map
`define DSPS_CTRL_OFS      8'h00
`define DSPS_STATUS_OFS    8'h04
`define DSPS_TINT_OFS      8'h08
`define DSPS_TAZ_OFS       8'h0C
`define DSPS_RESULT_OFS    8'h10
`define DSPS_CHAN_OFS      8'h14

// control fields
`define DSPS_CTRL_START    0
`define DSPS_CTRL_CONT     1

// status fields
`define DSPS_ST_BUSY       0
`define DSPS_ST_DONE       1
`define DSPS_ST_OVR        2
`define DSPS_ST_SIGN       3
`define DSPS_ST_PH_LO      4
`define DSPS_ST_PH_HI      5
`define DSPS_ST_ZC         6

// phase codes {first, second}
`define DSPS_PH_AZ         2'h1
`define DSPS_PH_INT        2'h2
`define DSPS_PH_REFERENCE_RUNDOWN_PHASE       2'h3
`define DSPS_PH_IZ         2'h0

// timing: 125 MHz clock, 8 ns period
`define DSPS_CLK_MHZ       125
`define DSPS_TINT_MS       66
`define DSPS_TINT_CYC      (`DSPS_TINT_MS * `DSPS_CLK_MHZ * 1000)
`define DSPS_CMP_DLY_US    2
`define DSPS_CMP_DLY_CYC   (`DSPS_CMP_DLY_US * `DSPS_CLK_MHZ)
`define DSPS_RESP_DECODE   2'h2

// reset values
`define DSPS_TINT_RST      32'h007DE290
`define DSPS_TAZ_RST       32'h007DE290

`endif

// File: core/dsps_sequencer.v
`include "dsps_regs.vh"

module dsps_sequencer (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        ce,
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        zero_cross_flag,
    output reg         phase_sel_a,
    output reg         phase_sel_b,
    output reg         channel_sel_high,
    output reg         channel_sel_low
);
    // sequencer states
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_AZ   = 3'h1;
    localparam [2:0] ST_INT  = 3'h2;
    localparam [2:0] ST_REFERENCE_RUNDOWN_PHASE = 3'h3;
    localparam [2:0] ST_IZ   = 3'h4;

    reg  [2:0]  state_q;
    reg  [31:0] tint_q;
    reg  [31:0] taz_q;
    reg  [31:0] tint_run_q;
    // counters one bit wider so twice the integrate length fits
    reg  [32:0] cnt_q;
    reg  [32:0] reference_rundown_phase_cnt_q;
    reg  [32:0] result_q;
    reg         sign_q;
    reg         ovr_q;
    reg         done_q;
    reg         cont_q;
    reg         start_q;
    reg  [1:0]  chan_q;
    reg         zc_prev_q;
    // each write channel held until its partner arrives
    reg         aw_got_q;
    reg         w_got_q;
    reg  [31:0] awaddr_q;
    reg  [31:0] wdata_q;
    reg  [3:0]  wstrb_q;
    wire        zc_level;
    // comparator falling edge, high in the same cycle the synchronised level drops
    wire        zc_fall;
    wire        wr_fire;
    wire        rd_fire;
    wire [32:0] reference_rundown_phase_max;
    reg  [31:0] rd_word;
    reg         rd_ok;

    // comparator is an asynchronous pin
    dsps_pin_sync u_zc_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .pin     (zero_cross_flag),
        .level   (zc_level)
    );

    assign zc_fall  = zc_prev_q & ~zc_level;
    // twice the integration count bounds the rundown
    assign reference_rundown_phase_max = {tint_run_q, 1'b0};

    // write channels accepted independently, response after both
    assign s_axi_awready = ~aw_got_q & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_got_q & ~s_axi_bvalid;
    assign wr_fire       = aw_got_q & w_got_q & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_fire       = s_axi_arvalid & s_axi_arready;

    // write address/data capture and response
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            awaddr_q     <= 32'h00000000;
            wdata_q      <= 32'h00000000;
            wstrb_q      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_got_q     <= 1'b0;
                w_got_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // read-only and unmapped offsets refused, no side effect
                case (awaddr_q[7:0])
                    `DSPS_CTRL_OFS, `DSPS_TINT_OFS, `DSPS_TAZ_OFS, `DSPS_CHAN_OFS: s_axi_bresp <= 2'h0;
                    default: s_axi_bresp <= `DSPS_RESP_DECODE;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read mux, unmapped addresses answer decode error
    always @* begin
        rd_word = 32'h00000000;
        rd_ok   = 1'b1;
        case (s_axi_araddr[7:0])
            `DSPS_CTRL_OFS:   rd_word = {30'h00000000, cont_q, 1'b0};
            `DSPS_STATUS_OFS: rd_word = {25'h0000000, zc_level, phase_sel_b, phase_sel_a,
                                         sign_q, ovr_q, done_q, (state_q != ST_IDLE)};
            `DSPS_TINT_OFS:   rd_word = tint_q;
            `DSPS_TAZ_OFS:    rd_word = taz_q;
            `DSPS_RESULT_OFS: rd_word = result_q[31:0];
            `DSPS_CHAN_OFS:   rd_word = {30'h00000000, chan_q};
            default:          rd_ok   = 1'b0;
        endcase
    end

    // read answer registered, held until rready
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= 2'h0;
        end else if (ce) begin
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_ok ? 2'h0 : `DSPS_RESP_DECODE;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // software-written configuration; done clears on result read
    always @(posedge aclk) begin
        if (!aresetn) begin
            tint_q  <= `DSPS_TINT_RST;
            taz_q   <= `DSPS_TAZ_RST;
            cont_q  <= 1'b0;
            start_q <= 1'b0;
            chan_q  <= 2'h0;
        end else if (ce) begin
            // consumed only as idle hands over to auto-zero, so a start
            // written mid-conversion waits for the next cycle
            if (state_q == ST_IDLE && start_q) begin
                start_q <= 1'b0;
            end
            if (wr_fire) begin
                case (awaddr_q[7:0])
                    `DSPS_CTRL_OFS: begin
                        if (wstrb_q[0]) begin
                            cont_q <= wdata_q[`DSPS_CTRL_CONT];
                            if (wdata_q[`DSPS_CTRL_START]) begin
                                start_q <= 1'b1;
                            end
                        end
                    end
                    `DSPS_TINT_OFS: tint_q <= wdata_q;
                    `DSPS_TAZ_OFS:  taz_q  <= wdata_q;
                    `DSPS_CHAN_OFS: begin
                        if (wstrb_q[0]) begin
                            chan_q <= wdata_q[1:0];
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // conversion sequencer; pin outputs registered
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_q          <= ST_IDLE;
            cnt_q            <= 33'h000000000;
            reference_rundown_phase_cnt_q       <= 33'h000000000;
            tint_run_q       <= `DSPS_TINT_RST;
            result_q         <= 33'h000000000;
            sign_q           <= 1'b0;
            ovr_q            <= 1'b0;
            done_q           <= 1'b0;
            zc_prev_q        <= 1'b0;
            // pins reset to auto-zero, the converter's safe idle
            phase_sel_a      <= 1'b0;
            phase_sel_b      <= 1'b1;
            channel_sel_high <= 1'b0;
            channel_sel_low  <= 1'b0;
        end else if (ce) begin
            zc_prev_q <= zc_level;
            // reading the result clears done, a new completion wins
            if (rd_fire && s_axi_araddr[7:0] == `DSPS_RESULT_OFS) begin
                done_q <= 1'b0;
            end
            case (state_q)
                ST_IDLE: begin
                    // park in auto-zero, comparator ignored here
                    {phase_sel_a, phase_sel_b} <= `DSPS_PH_AZ;
                    if (start_q || cont_q) begin
                        channel_sel_high <= chan_q[1];
                        channel_sel_low  <= chan_q[0];
                        tint_run_q       <= tint_q;
                        cnt_q            <= 33'h000000000;
                        state_q          <= ST_AZ;
                    end
                end
                ST_AZ: begin
                    // own length register, normally set equal to integrate
                    {phase_sel_a, phase_sel_b} <= `DSPS_PH_AZ;
                    if (cnt_q + 33'h1 >= {1'b0, taz_q}) begin
                        cnt_q   <= 33'h000000000;
                        {phase_sel_a, phase_sel_b} <= `DSPS_PH_INT;
                        state_q <= ST_INT;
                    end else begin
                        cnt_q <= cnt_q + 33'h1;
                    end
                end
                ST_INT: begin
                    if (cnt_q + 33'h1 >= {1'b0, tint_run_q}) begin
                        // last sample of the phase is the sign
                        sign_q     <= zc_level;
                        reference_rundown_phase_cnt_q <= 33'h000000000;
                        {phase_sel_a, phase_sel_b} <= `DSPS_PH_REFERENCE_RUNDOWN_PHASE;
                        state_q    <= ST_REFERENCE_RUNDOWN_PHASE;
                    end else begin
                        cnt_q <= cnt_q + 33'h1;
                    end
                end
                ST_REFERENCE_RUNDOWN_PHASE: begin
                    // counts from the 10->11 edge to the falling crossing;
                    // includes sync and ~2 us comparator latency
                    if (zc_fall) begin
                        result_q <= reference_rundown_phase_cnt_q;
                        ovr_q    <= 1'b0;
                        done_q   <= 1'b1;
                        {phase_sel_a, phase_sel_b} <= `DSPS_PH_IZ;
                        state_q  <= ST_IZ;
                    end else if (reference_rundown_phase_cnt_q >= reference_rundown_phase_max) begin
                        // no crossing within twice the integrate count
                        result_q <= reference_rundown_phase_cnt_q;
                        ovr_q    <= 1'b1;
                        done_q   <= 1'b1;
                        {phase_sel_a, phase_sel_b} <= `DSPS_PH_IZ;
                        state_q  <= ST_IZ;
                    end else begin
                        reference_rundown_phase_cnt_q <= reference_rundown_phase_cnt_q + 33'h1;
                    end
                end
                ST_IZ: begin
                    // level watched directly: leave at once when high;
                    // after overrange it never fell, so this ends at once
                    if (zc_level) begin
                        {phase_sel_a, phase_sel_b} <= `DSPS_PH_AZ;
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule

// File: testbench/dsps_conv_model.sv
module dsps_conv_model (
    input  wire        aclk,
    input  wire        phase_sel_a,
    input  wire        phase_sel_b,
    input  wire        positive,
    input  wire [15:0] fall_after,
    output logic       zero_cross_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0]  ph_q = 2'h1;
    logic [15:0] cnt_q = 16'h0;
    // pins read afresh each cycle; the previous phase is kept in ph_q for the count
    wire  [1:0]  ph = {phase_sel_a, phase_sel_b};
    wire  [15:0] cnt = (ph == ph_q) ? cnt_q + 16'h1 : 16'h0;
    initial zero_cross_flag = 1'b0;
    // comparator level per phase; fall_after of zero never crosses
    always @(posedge aclk) begin
        ph_q <= ph;
        cnt_q <= cnt;
        case (ph)
            2'h1: zero_cross_flag <= ~zero_cross_flag; // undefined while parked, never steady
            2'h2: zero_cross_flag <= (cnt < 16'h3) ? ~zero_cross_flag : positive; // noisy start, then sign
            2'h3: zero_cross_flag <= (fall_after == 16'h0) || (cnt < fall_after); // one fall at crossing
            default: zero_cross_flag <= (cnt > 16'h3); // high again once overshoot is cleared
        endcase
    end
endmodule

// File: testbench/dsps_props.sv
module dsps_props (
    input wire       aclk,
    input wire       aresetn,
    input wire       s_axi_bvalid,
    input wire       s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire       zero_cross_flag,
    input wire       phase_sel_a,
    input wire       phase_sel_b,
    input wire       channel_sel_high,
    input wire       channel_sel_low
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int INT_CYC = 32'h14; // integrate length the bench programs
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    wire  [1:0]  ph = {phase_sel_a, phase_sel_b};
    logic [31:0] int_q;
    // integrate cycles so far, cleared outside that phase
    always @(posedge aclk) begin
        if (!aresetn || ph != 2'h2) int_q <= 32'h0;
        else int_q <= int_q + 32'h1;
    end
    // one step out of phase p
    sequence s_leave(logic [1:0] p);
        ph == p ##1 ph != p;
    endsequence
    a_az_next: assert property (s_leave(2'h1) |-> ph == 2'h2) else $error("bad step from auto-zero");
    a_int_next: assert property (s_leave(2'h2) |-> ph == 2'h3) else $error("bad step from integrate");
    a_reference_rundown_phase_next: assert property (s_leave(2'h3) |-> ph == 2'h0) else $error("bad step from rundown");
    a_iz_next: assert property (s_leave(2'h0) |-> ph == 2'h1) else $error("bad step from clear");
    a_int_len: assert property (s_leave(2'h2) |-> int_q == INT_CYC) else $error("integrate length off");
    a_iz_exit: assert property (ph == 2'h0 && $rose(zero_cross_flag) |-> ##[1:8] ph == 2'h1)
        else $error("clear phase held too long");
    a_iz_hold: assert property (s_leave(2'h0) |-> $past(zero_cross_flag, 2)) else $error("clear left early");
    a_chan_steady: assert property (ph != 2'h1 |=> $stable({channel_sel_high, channel_sel_low}))
        else $error("channel moved mid conversion");
    a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("response repeated");
    a_bresp_legal: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
        else $error("bad write response code");
endmodule

bind dsps_sequencer dsps_props u_props (
    .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .zero_cross_flag,
    .phase_sel_a, .phase_sel_b, .channel_sel_high, .channel_sel_low
);

// File: testbench/tb.sv
`include "dsps_regs.vh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [31:0] s_axi_araddr = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        positive = 1'b1;
    logic [15:0] fall_after = 16'h8;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, zero_cross_flag;
    wire         phase_sel_a, phase_sel_b, channel_sel_high, channel_sel_low;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    logic [31:0] rv;
    int          bad_count = 0;
    int          check_count = 0;
    int          cycles = 0;

    always #4 aclk = ~aclk;

    dsps_sequencer dut (
        .aclk, .aresetn, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .zero_cross_flag, .phase_sel_a, .phase_sel_b, .channel_sel_high, .channel_sel_low
    );
    dsps_conv_model u_conv (.aclk, .phase_sel_a, .phase_sel_b, .positive, .fall_after, .zero_cross_flag);

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // hang guard, far above the under one thousand cycles the tests need
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= {24'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rv = s_axi_rdata;
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    // poll status until bit b reads v, bounded
    task automatic wait_bit(input int b, input logic v);
        int n;
        n = 0;
        do begin
            rd(`DSPS_STATUS_OFS, 2'h0);
            n++;
        end while (rv[b] !== v && n < 400);
        chk({31'h0, rv[b]}, {31'h0, v});
    endtask

    // one conversion; a zero fall count means the crossing never comes
    task automatic conv(input logic [1:0] ch, input logic pos, input logic [15:0] fall);
        positive <= pos;
        fall_after <= fall;
        wr(`DSPS_CHAN_OFS, {30'h0, ch}, 2'h0);
        wr(`DSPS_CTRL_OFS, 32'h1, 2'h0);
        wait_bit(`DSPS_ST_DONE, 1'b1);
        chk({31'h0, rv[`DSPS_ST_SIGN]}, {31'h0, pos});
        chk({31'h0, rv[`DSPS_ST_OVR]}, {31'h0, fall == 16'h0});
        chk({30'h0, channel_sel_high, channel_sel_low}, {30'h0, ch});
        rd(`DSPS_RESULT_OFS, 2'h0);
        if (fall != 16'h0) chk({31'h0, rv >= fall + 1 && rv <= fall + 7}, 32'h1);
        else chk({31'h0, rv >= 32'h28 && rv <= 32'h2A}, 32'h1);
        wait_bit(`DSPS_ST_BUSY, 1'b0);
        chk({30'h0, rv[5:4]}, 32'h2);
        chk({31'h0, rv[`DSPS_ST_DONE]}, 32'h0);
    endtask

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`DSPS_TINT_OFS, 2'h0);
        chk(rv, `DSPS_TINT_RST);
        rd(`DSPS_TAZ_OFS, 2'h0);
        chk(rv, `DSPS_TAZ_RST);
        rd(`DSPS_STATUS_OFS, 2'h0);
        chk({27'h0, rv[5:4], rv[2:0]}, 32'h10);
        rd(8'h18, 2'h2);
        chk(rv, 32'h0);
        wr(`DSPS_STATUS_OFS, 32'h0, 2'h2);
        wr(`DSPS_TINT_OFS, 32'h14, 2'h0);
        wr(`DSPS_TAZ_OFS, 32'h14, 2'h0);
        rd(`DSPS_TINT_OFS, 2'h0);
        chk(rv, 32'h14);
        // channel write with its byte strobe low leaves the channel alone
        s_axi_wstrb <= 4'h0;
        wr(`DSPS_CHAN_OFS, 32'h3, 2'h0);
        s_axi_wstrb <= 4'hF;
        rd(`DSPS_CHAN_OFS, 2'h0);
        chk(rv, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 4; i++) conv(i[1:0], i[0], {11'h0, i[1:0], 3'h4});
        $display("test conversions done");
        conv(2'h1, 1'b1, 16'h0);
        $display("test overrange done");
        // a start during a conversion is kept for the next one
        fall_after <= 16'h8;
        wr(`DSPS_CTRL_OFS, 32'h1, 2'h0);
        wr(`DSPS_CTRL_OFS, 32'h1, 2'h0);
        wait_bit(`DSPS_ST_DONE, 1'b1);
        rd(`DSPS_RESULT_OFS, 2'h0);
        wait_bit(`DSPS_ST_DONE, 1'b1);
        wait_bit(`DSPS_ST_BUSY, 1'b0);
        $display("test queued start done");
        // continuous mode restarts with no further start write
        rd(`DSPS_RESULT_OFS, 2'h0);
        wr(`DSPS_CTRL_OFS, 32'h2, 2'h0);
        wait_bit(`DSPS_ST_DONE, 1'b1);
        rd(`DSPS_RESULT_OFS, 2'h0);
        wait_bit(`DSPS_ST_DONE, 1'b1);
        rd(`DSPS_CTRL_OFS, 2'h0);
        chk(rv, 32'h2);
        wr(`DSPS_CTRL_OFS, 32'h0, 2'h0);
        wait_bit(`DSPS_ST_BUSY, 1'b0);
        $display("test continuous done");
        summarize();
    end
endmodule
